// ==== logic/sideband_pkg.sv ====
package sideband_pkg;

  // ==========================================================
  // register map
  localparam logic [3:0] OFF_MODE = 4'h0;
  localparam logic [3:0] OFF_BASIC = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  localparam logic [3:0] OFF_MGMT = 4'hC;

  // ==========================================================
  // fields and reset values
  localparam int MODE_MASTER_BIT = 2;
  localparam int BASIC_ISO_BIT = 10;
  localparam int BASIC_AN_BIT = 12;
  localparam int MGMT_OUT_BIT = 0;
  localparam int MGMT_DRV_BIT = 1;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [15:0] BASIC_RST = 16'h0000;
  localparam logic [1:0] MGMT_RST = 2'h0;
  localparam logic [3:0] ABIL_FULL = 4'hF;
  localparam logic [3:0] ABIL_HALF = 4'h5;
  localparam logic [3:0] ABIL_NONE = 4'h0;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MDC_PERIOD_NS = 400;
  localparam int MDC_HALF_CYC = MDC_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MEDIA_MAC = 2'h0,
    MEDIA_PHY = 2'h1,
    MEDIA_RMII = 2'h2
  } media_mode_e;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_e;

  typedef struct packed {
    logic mgmt_master;
    logic [1:0] media;
  } mode_s;

  typedef struct packed {
    logic carrier;
    logic duplex;
    logic strap;
    logic mdio;
    logic mdc;
  } pin_in_s;

endpackage : sideband_pkg

// ==== logic/bit_sync.sv ====
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ==========================================================
  // two-stage synchroniser
  logic [W-1:0] meta_r;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : bit_sync

// ==== logic/mgmt_clock_gen.sv ====
`timescale 1ns/1ps
module mgmt_clock_gen
  import sideband_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic enable,
  output logic mdc_r,
  output logic rise_r
);

  // ==========================================================
  // divider for the management clock
  localparam logic [7:0] HALF_LAST = 8'(MDC_HALF_CYC - 1);
  logic [7:0] cnt_r;
  wire wrap = (cnt_r == HALF_LAST);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 8'h00;
      mdc_r <= 1'b0;
      rise_r <= 1'b0;
    end else if (!enable) begin
      cnt_r <= 8'h00;
      mdc_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      cnt_r <= wrap ? 8'h00 : cnt_r + 8'h01;
      mdc_r <= wrap ? ~mdc_r : mdc_r;
      rise_r <= wrap && !mdc_r;
    end
  end

endmodule : mgmt_clock_gen

// ==== logic/port0_sideband_mgmt_pin_ctrl.sv ====
`timescale 1ns/1ps
module port0_sideband_mgmt_pin_ctrl
  import sideband_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic core_carrier,
  input wire logic negotiated_duplex,
  output logic carrier_detect,
  output logic duplex_full,
  output logic [3:0] partner_ability,
  input wire logic port0_duplex_polarity_strap,
  input wire logic port0_carrier_sense_i,
  output logic port0_carrier_sense_o,
  output logic port0_carrier_sense_oe,
  input wire logic port0_duplex_in,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic mdc_i,
  output logic mdc_o,
  output logic mdc_oe
);

  // ==========================================================
  // helpers
  function automatic logic [31:0] be_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

  // ==========================================================
  // state
  mode_s mode_r;
  logic [15:0] basic_r;
  logic [1:0] mgmt_r;
  logic [15:0] shift_r;
  bus_state_e bus_state_r;
  logic strap_r;
  logic [1:0] strap_cnt_r;
  logic mdc_prev_r;
  logic drive_en_r;
  logic carrier_lvl_r;
  pin_in_s pin_sync;
  logic gen_mdc;
  logic gen_rise;
  logic [31:0] rd_mux;

  // ==========================================================
  // pin synchronisers
  bit_sync #(.W(5)) u_pin_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .d({port0_carrier_sense_i, port0_duplex_in, port0_duplex_polarity_strap, mdio_i, mdc_i}),
    .q(pin_sync)
  );

  // ==========================================================
  // decode
  wire is_mac = (mode_r.media == MEDIA_MAC);
  wire is_phy = (mode_r.media == MEDIA_PHY);
  wire iso = basic_r[BASIC_ISO_BIT];
  wire an_en = basic_r[BASIC_AN_BIT];
  wire master = mode_r.mgmt_master;
  wire dup_pin = pin_sync.duplex ^ strap_r;
  wire hit_mode = (avs_address == OFF_MODE);
  wire hit_basic = (avs_address == OFF_BASIC);
  wire hit_status = (avs_address == OFF_STATUS);
  wire hit_mgmt = (avs_address == OFF_MGMT);
  wire req = avs_read || avs_write;
  wire commit_wr = avs_write && (bus_state_r == BUS_ACK);
  wire mdc_in_rise = pin_sync.mdc && !mdc_prev_r;
  wire sample_edge = master ? gen_rise : mdc_in_rise;
  wire drive_en_nxt = is_phy && !iso;
  wire carrier_det_nxt = is_mac && pin_sync.carrier;
  wire duplex_nxt = (is_mac && an_en) ? negotiated_duplex : dup_pin;
  wire [3:0] abil_nxt = is_mac ? ABIL_NONE : (dup_pin ? ABIL_FULL : ABIL_HALF);
  wire [31:0] wr_mode = be_merge({29'h0, mode_r}, avs_writedata, avs_byteenable);
  wire [31:0] wr_basic = be_merge({16'h0, basic_r}, avs_writedata, avs_byteenable);
  wire [31:0] wr_mgmt = be_merge({30'h0, mgmt_r}, avs_writedata, avs_byteenable);

  always_comb begin
    if (hit_mode) begin
      rd_mux = {29'h0, mode_r};
    end else if (hit_basic) begin
      rd_mux = {16'h0, basic_r};
    end else if (hit_status) begin
      rd_mux = {24'h0, partner_ability, strap_r, duplex_full, pin_sync.duplex, carrier_detect};
    end else if (hit_mgmt) begin
      rd_mux = {shift_r, 12'h0, pin_sync.mdc, pin_sync.mdio, mgmt_r};
    end else begin
      rd_mux = 32'h0;
    end
  end

  // ==========================================================
  // bus slave
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bus_state_r <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      case (bus_state_r)
        BUS_IDLE: begin
          if (req) begin
            bus_state_r <= BUS_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata <= rd_mux;
          end
        end
        default: begin
          bus_state_r <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r <= MODE_RST;
      basic_r <= BASIC_RST;
      mgmt_r <= MGMT_RST;
    end else if (commit_wr) begin
      if (hit_mode) begin
        mode_r <= wr_mode[2:0];
      end else if (hit_basic) begin
        basic_r <= wr_basic[15:0];
      end else if (hit_mgmt) begin
        mgmt_r <= wr_mgmt[1:0];
      end
    end
  end

  // ==========================================================
  // strap capture after reset release
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      strap_cnt_r <= 2'h0;
      strap_r <= 1'b0;
    end else if (strap_cnt_r < STRAP_SETTLE) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
    end else if (strap_cnt_r == STRAP_SETTLE) begin
      // one-shot latch, later pin changes ignored
      strap_cnt_r <= strap_cnt_r + 2'h1;
      strap_r <= pin_sync.strap;
    end
  end

  // ==========================================================
  // carrier and duplex
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      drive_en_r <= 1'b0;
      carrier_lvl_r <= 1'b0;
      carrier_detect <= 1'b0;
      duplex_full <= 1'b0;
      partner_ability <= ABIL_NONE;
    end else begin
      drive_en_r <= drive_en_nxt;
      carrier_lvl_r <= is_phy && core_carrier;
      carrier_detect <= carrier_det_nxt;
      duplex_full <= duplex_nxt;
      partner_ability <= abil_nxt;
    end
  end

  // link-side driver of the carrier-sense pin
  bit_sync #(.W(2)) u_link_sync (
    .clock(link_clk),
    .sys_rst(sys_rst),
    .d({drive_en_r, carrier_lvl_r}),
    .q({port0_carrier_sense_oe, port0_carrier_sense_o})
  );

  // ==========================================================
  // management pins
  mgmt_clock_gen u_mdc_gen (
    .clock(clock),
    .sys_rst(sys_rst),
    .enable(master),
    .mdc_r(gen_mdc),
    .rise_r(gen_rise)
  );

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
      mdc_o <= 1'b0;
      mdc_oe <= 1'b0;
      mdc_prev_r <= 1'b0;
      shift_r <= 16'h0;
    end else begin
      mdio_o <= mgmt_r[MGMT_OUT_BIT];
      mdio_oe <= mgmt_r[MGMT_DRV_BIT];
      mdc_o <= gen_mdc;
      mdc_oe <= master;
      mdc_prev_r <= pin_sync.mdc;
      if (sample_edge) begin
        shift_r <= {shift_r[14:0], pin_sync.mdio};
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_mac_carrier_in;
    (is_mac && pin_sync.carrier) |=> carrier_detect;
  endproperty
  a_mac_carrier_in: assert property (p_mac_carrier_in)
    else $error("carrier not seen in mac mode");

  property p_phy_drive;
    (is_phy && !iso) |=> (drive_en_r && carrier_lvl_r == $past(core_carrier));
  endproperty
  a_phy_drive: assert property (p_phy_drive)
    else $error("carrier not driven in phy mode");

  property p_iso_off;
    iso |=> !drive_en_r;
  endproperty
  a_iso_off: assert property (p_iso_off)
    else $error("carrier driven while isolated");

  property p_rmii_unused;
    (mode_r.media == MEDIA_RMII) |=> (!carrier_detect && !drive_en_r);
  endproperty
  a_rmii_unused: assert property (p_rmii_unused)
    else $error("carrier pin used in reduced mode");

  property p_link_oe;
    @(posedge link_clk) disable iff (sys_rst)
      port0_carrier_sense_oe |-> $past(drive_en_r, 2);
  endproperty
  a_link_oe: assert property (p_link_oe)
    else $error("link driver enabled without cause");

  property p_dup_live;
    (is_mac && !an_en) |=> (duplex_full == $past(dup_pin));
  endproperty
  a_dup_live: assert property (p_dup_live)
    else $error("duplex pin not followed");

  property p_dup_an;
    (is_mac && an_en) |=> (duplex_full == $past(negotiated_duplex));
  endproperty
  a_dup_an: assert property (p_dup_an)
    else $error("negotiated duplex not used");

  property p_ability;
    !is_mac |=> (partner_ability == ($past(dup_pin) ? ABIL_FULL : ABIL_HALF));
  endproperty
  a_ability: assert property (p_ability)
    else $error("ability bits wrong");

  property p_slave_mdio;
    (!master && !mgmt_r[MGMT_DRV_BIT]) |=> !mdio_oe;
  endproperty
  a_slave_mdio: assert property (p_slave_mdio)
    else $error("mdio driven without request");

  property p_master_mdio;
    (master && mgmt_r[MGMT_DRV_BIT]) |=> (mdio_oe && mdio_o == $past(mgmt_r[MGMT_OUT_BIT]));
  endproperty
  a_master_mdio: assert property (p_master_mdio)
    else $error("mdio write not driven");

  property p_slave_mdc;
    !master |=> !mdc_oe;
  endproperty
  a_slave_mdc: assert property (p_slave_mdc)
    else $error("mdc driven as slave");

  property p_master_mdc;
    (master && mdc_oe && !mdc_o) |-> ##[1:41] mdc_o;
  endproperty
  a_master_mdc: assert property (p_master_mdc)
    else $error("mdc not toggling");

  property p_dir_stable;
    ($stable(mode_r) && $stable(iso)) |=> ($stable(mdc_oe) && $stable(drive_en_r));
  endproperty
  a_dir_stable: assert property (p_dir_stable)
    else $error("direction changed without mode change");

endmodule : port0_sideband_mgmt_pin_ctrl

// ==== bench/sideband_far_model.sv ====
`timescale 1ns/1ps
module sideband_far_model (
  input wire logic clock,
  input wire logic crs_lvl,
  input wire logic crs_drv,
  input wire logic mdc_run,
  input wire logic mdio_val,
  input wire logic mdio_drv,
  input wire logic crs_o,
  input wire logic crs_oe,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  input wire logic mdc_o,
  input wire logic mdc_oe,
  output logic crs_pin,
  output logic mdio_pin,
  output logic mdc_pin
);
  // ==========================================================
  // external master clock, still when idle
  logic mck_r = 1'h0;
  logic [2:0] div_r = 3'h0;
  always_ff @(posedge clock) begin
    div_r <= div_r + 3'h1;
    if (!mdc_run) mck_r <= 1'h0;
    else if (div_r == 3'h7) mck_r <= !mck_r;
  end
  // ==========================================================
  // pin levels, pulls and contention
  assign crs_pin = (crs_oe && crs_drv) ? 1'hx : crs_oe ? crs_o : crs_drv ? crs_lvl : 1'h0;
  assign mdio_pin = (mdio_oe && mdio_drv) ? 1'hx : mdio_oe ? mdio_o : mdio_drv ? mdio_val : 1'h1;
  assign mdc_pin = (mdc_oe && mdc_run) ? 1'hx : mdc_oe ? mdc_o : mck_r;
endmodule : sideband_far_model

// ==== bench/test_port0_sideband_mgmt_pin_ctrl.sv ====
`timescale 1ns/1ps
module test_port0_sideband_mgmt_pin_ctrl
  import sideband_pkg::*;
;
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
  logic clock = 1'h0, sys_rst = 1'h1, link_clk = 1'h0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
  logic avs_read = 1'h0, avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic core_carrier = 1'h0, negotiated_duplex = 1'h0, port0_duplex_in = 1'h1;
  logic port0_duplex_polarity_strap = 1'h0;
  logic crs_lvl = 1'h0, crs_drv = 1'h0, mdc_run = 1'h0, mdio_val = 1'h1, mdio_drv = 1'h0;
  logic avs_waitrequest, carrier_detect, duplex_full, port0_carrier_sense_o;
  logic port0_carrier_sense_oe, mdio_o, mdio_oe, mdc_o, mdc_oe, iso, an, prev;
  logic [3:0] partner_ability;
  wire logic port0_carrier_sense_i, mdio_i, mdc_i;
  int bad_count = 0, num_checks = 0, rises;

  port0_sideband_mgmt_pin_ctrl dut (.clock, .sys_rst, .link_clk, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .core_carrier, .negotiated_duplex, .carrier_detect, .duplex_full, .partner_ability,
    .port0_duplex_polarity_strap, .port0_carrier_sense_i, .port0_carrier_sense_o,
    .port0_carrier_sense_oe, .port0_duplex_in, .mdio_i, .mdio_o, .mdio_oe, .mdc_i, .mdc_o,
    .mdc_oe);
  sideband_far_model far (.clock, .crs_lvl, .crs_drv, .mdc_run, .mdio_val, .mdio_drv,
    .crs_o(port0_carrier_sense_o), .crs_oe(port0_carrier_sense_oe), .mdio_o, .mdio_oe,
    .mdc_o, .mdc_oe, .crs_pin(port0_carrier_sense_i), .mdio_pin(mdio_i), .mdc_pin(mdc_i));

  // ==========================================================
  // clocks and watchdog
  initial begin
    forever #5 clock = ~clock;
  end
  initial begin
    #3.3;
    forever #62.5 link_clk = ~link_clk;
  end
  initial begin
    #200000;
    bad_count++;
    summarize();
  end

  // ==========================================================
  // bus access and expectations
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 20);
    `CHK(avs_waitrequest, 1'h0)
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clock);
  endtask : bus

  function automatic logic [3:0] exp_abil(int m, logic pin);
    if (m == 0) return ABIL_NONE;
    return (pin ^ port0_duplex_polarity_strap) ? ABIL_FULL : ABIL_HALF;
  endfunction : exp_abil

  function automatic logic exp_dup(logic a, logic neg, logic pin);
    return a ? neg : (pin ^ port0_duplex_polarity_strap);
  endfunction : exp_dup

  task automatic summarize();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(92));
    repeat (6) @(posedge clock);
    `CHK(avs_waitrequest, 1'h1)
    sys_rst <= 1'h0;
    @(posedge clock);
    bus(1'h0, OFF_MODE, 32'h0);
    `CHK(rd, {29'h0, MODE_RST})
    bus(1'h0, OFF_BASIC, 32'h0);
    `CHK(rd, {16'h0, BASIC_RST})
    `CHK(mdc_oe, 1'h0)
    bus(1'h1, 4'h2, 32'hFFFFFFFF);
    avs_byteenable <= 4'h0;
    bus(1'h1, OFF_MODE, 32'h1);
    avs_byteenable <= 4'hF;
    bus(1'h0, 4'h2, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'h0, OFF_MODE, 32'h0);
    `CHK(rd, 32'h0)
    for (int m = 0; m < 3; m++) begin
      for (int k = 0; k < 4; k++) begin
        iso = k[0];
        an = k[1];
        core_carrier <= 1'($urandom);
        negotiated_duplex <= 1'($urandom);
        port0_duplex_in <= 1'($urandom);
        crs_lvl <= 1'($urandom);
        crs_drv <= (m != 1);
        bus(1'h1, OFF_MODE, 32'(m));
        bus(1'h1, OFF_BASIC, {19'h0, an, 1'h0, iso, 10'h0});
        repeat (40) @(posedge clock);
        `CHK(partner_ability, exp_abil(m, port0_duplex_in))
        if (m == 1) begin
          `CHK(port0_carrier_sense_oe, !iso)
          if (!iso) `CHK(port0_carrier_sense_o, core_carrier)
        end else if (m == 2) begin
          `CHK(port0_carrier_sense_oe, 1'h0)
          `CHK(carrier_detect, 1'h0)
        end else begin
          `CHK(port0_carrier_sense_oe, 1'h0)
          `CHK(carrier_detect, crs_lvl)
          `CHK(duplex_full, exp_dup(an, negotiated_duplex, port0_duplex_in))
          port0_duplex_in <= !port0_duplex_in;
          repeat (10) @(posedge clock);
          `CHK(duplex_full, exp_dup(an, negotiated_duplex, port0_duplex_in))
        end
      end
    end
    crs_drv <= 1'h0;
    bus(1'h1, OFF_MODE, 32'h0);
    mdio_drv <= 1'h1;
    mdc_run <= 1'h1;
    repeat (300) @(posedge clock);
    bus(1'h0, OFF_MGMT, 32'h0);
    `CHK(rd[31:16], 16'hFFFF)
    `CHK(mdc_oe, 1'h0)
    `CHK(mdio_oe, 1'h0)
    mdio_val <= 1'h0;
    repeat (300) @(posedge clock);
    bus(1'h0, OFF_MGMT, 32'h0);
    `CHK(rd[31:16], 16'h0000)
    `CHK(rd[2], 1'h0)
    mdio_drv <= 1'h0;
    mdc_run <= 1'h0;
    bus(1'h1, OFF_MGMT, 32'h3);
    repeat (4) @(posedge clock);
    `CHK(mdio_oe, 1'h1)
    `CHK(mdio_o, 1'h1)
    bus(1'h1, OFF_MODE, 32'h4);
    bus(1'h1, OFF_MGMT, 32'h2);
    repeat (4) @(posedge clock);
    `CHK(mdc_oe, 1'h1)
    `CHK(mdio_o, 1'h0)
    rises = 0;
    prev = mdc_o;
    repeat (80) begin
      @(posedge clock);
      rises += int'(mdc_o && !prev);
      prev = mdc_o;
    end
    `CHK(rises, 2)
    bus(1'h0, OFF_MGMT, 32'h0);
    `CHK(rd[2], 1'h0)
    bus(1'h1, OFF_MGMT, 32'h0);
    repeat (700) @(posedge clock);
    bus(1'h0, OFF_MGMT, 32'h0);
    `CHK(rd[2], 1'h1)
    `CHK(rd[31:16], 16'hFFFF)
    bus(1'h1, OFF_MODE, 32'h0);
    repeat (4) @(posedge clock);
    `CHK(mdc_oe, 1'h0)
    // ==========================================================
    // mid-run reset with inverted duplex strap, alternate reduced code
    port0_duplex_polarity_strap <= 1'h1;
    crs_drv <= 1'h1;
    crs_lvl <= 1'h1;
    port0_duplex_in <= 1'($urandom);
    sys_rst <= 1'h1;
    repeat (14) @(posedge clock);
    `CHK(avs_waitrequest, 1'h1)
    sys_rst <= 1'h0;
    repeat (6) @(posedge clock);
    bus(1'h0, OFF_MODE, 32'h0);
    `CHK(rd, {29'h0, MODE_RST})
    bus(1'h1, OFF_MODE, 32'h3);
    repeat (40) @(posedge clock);
    `CHK(partner_ability, exp_abil(3, port0_duplex_in))
    `CHK(port0_carrier_sense_oe, 1'h0)
    `CHK(carrier_detect, 1'h0)
    bus(1'h0, OFF_STATUS, 32'h0);
    `CHK(rd[3], 1'h1)
    `CHK(rd[7:4], exp_abil(3, port0_duplex_in))
    `CHK(rd[0], 1'h0)
    summarize();
  end
endmodule : test_port0_sideband_mgmt_pin_ctrl
